// [logic/slp_pkg.sv]
// package: register map, field positions and clock ratios of the serial lane front end
package slp_pkg;
    localparam int unsigned ADDR_W          = 12;
    localparam int unsigned DATA_W          = 8;
    localparam int unsigned LANES           = 8;
    // register offsets
    localparam logic [11:0] OFS_IF_POWER    = 12'h200;
    localparam logic [11:0] OFS_LANE_PD     = 12'h201;
    localparam logic [11:0] OFS_EQ_MODE     = 12'h268;
    localparam logic [11:0] OFS_PLL_CTRL    = 12'h280;
    localparam logic [11:0] OFS_PLL_STAT    = 12'h281;
    localparam logic [11:0] OFS_PLL_DIV     = 12'h289;
    localparam logic [11:0] OFS_TUNE_FIRST  = 12'h284;
    localparam logic [11:0] OFS_TUNE_LAST   = 12'h2a0;
    localparam logic [11:0] OFS_TERM_A      = 12'h2a7;
    localparam logic [11:0] OFS_TERM_B      = 12'h2ae;
    localparam logic [11:0] OFS_CDR_RESET   = 12'h206;
    // wishbone-side registers of the controller
    localparam logic [3:0]  WB_CMD_ADDR     = 4'h0;
    localparam logic [3:0]  WB_WDATA        = 4'h4;
    localparam logic [3:0]  WB_RDATA        = 4'h8;
    localparam logic [3:0]  WB_STATUS       = 4'hc;
    // field positions
    localparam int unsigned BIT_IF_PD       = 0;
    localparam int unsigned BIT_PLL_EN      = 0;
    localparam int unsigned BIT_PLL_RECAL   = 2;
    localparam int unsigned BIT_LOCK        = 0;
    localparam int unsigned BIT_CAL_DONE    = 3;
    localparam int unsigned BIT_BAND_HI     = 4;
    localparam int unsigned BIT_BAND_LO     = 5;
    localparam int unsigned BIT_CDR_RESET   = 0;
    localparam int unsigned EQ_MSB          = 7;
    localparam int unsigned EQ_LSB          = 6;
    localparam logic [1:0]  EQ_NORMAL       = 2'h0;
    localparam logic [1:0]  EQ_LOW_POWER    = 2'h1;
    localparam logic [7:0]  TERM_START      = 8'h01;
    // divider codes and ratios
    localparam logic [1:0]  DIV_HALF        = 2'h0;
    localparam logic [1:0]  DIV_FULL        = 2'h1;
    localparam logic [1:0]  DIV_OVERSAMP    = 2'h2;
    localparam int unsigned BITS_PER_BYTE   = 10;
    localparam int unsigned BYTES_PER_PCLK  = 4;
    localparam int unsigned VCO_POSTDIV     = 2;
    localparam int unsigned REF_RATIO       = BITS_PER_BYTE * BYTES_PER_PCLK;
    // reset values
    localparam logic [7:0]  RST_IF_POWER    = 8'h01;
    localparam logic [7:0]  RST_ZERO        = 8'h00;
    // calibration, lock and termination timing in clk_i cycles (model of the analog settling)
    localparam logic [7:0]  CAL_CYCLES      = 8'h20;
    localparam logic [7:0]  LOCK_CYCLES     = 8'h10;
    localparam logic [7:0]  TERM_CYCLES     = 8'h08;
endpackage

// [logic/slp_if.sv]
// interface: register port between the front end and its controller
`timescale 1ns/10ps
interface slp_if;
    logic        req;
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        ack;
    modport dev  (input req, we, addr, wdata, output rdata, ack);
    modport ctrl (output req, we, addr, wdata, input rdata, ack);
endinterface

// [logic/slp_phy_pll.sv]
// module: serial lane front end control, status and pll model
`timescale 1ns/10ps
// Functional notes
// - interface powered down until bit 0 cleared
// - one power-down bit per lane, 1 off
// - 0x01 to group a starts termination tune
// - 0x01 to group b starts termination tune
// - equalizer mode field bits 7:6
// - byte rate is lane rate over ten
// - processing clock is byte rate over four
// - frames per processing cycle equal 4/F
// - pll reference is lane rate over forty
// - software keeps detector clock in window
// - divider code 2/1/0 divides by 1/2/4
// - set divider before pll enable bit
// - status bit 0 shows pll lock
// - status bit 3 shows calibration done
// - band-limit bits; recalibrate via bit 2 rise
// - oscillator divided by two for lanes
// - software writes recommended tuning values
// - software pulses recovery reset bit 0
// - half rate recovery above full-rate limit
module slp_phy_pll #(
    parameter int unsigned LANES   = slp_pkg::LANES,
    parameter int unsigned F_OCTET = 1
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // register port
    slp_if.dev                     bus,
    // analog band-limit indications
    input  wire logic              band_hi_i,
    input  wire logic              band_lo_i,
    // control to the analog and lane logic
    output logic                   if_powered_o,
    output logic [LANES-1:0]       lane_active_o,
    output logic [LANES-1:0]       term_tuning_o,
    output logic [1:0]             eq_mode_o,
    output logic                   cdr_reset_o,
    output logic [2:0]             ref_divide_o,
    output logic [7:0]             bytes_per_pclk_o,
    output logic [7:0]             frames_per_pclk_o,
    output logic [7:0]             ref_ratio_o,
    output logic [7:0]             vco_postdiv_o
);
    typedef enum logic [1:0] {
        SLP_OFF  = 2'b00,
        SLP_CAL  = 2'b01,
        SLP_LOCK = 2'b10,
        SLP_RUN  = 2'b11
    } slp_pll_t;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0]       if_power_q, pd_q, eq_q, ctrl_q, div_q, term_a_q, term_b_q, cdr_q;
    logic [7:0]       tune_q [0:28];
    logic [7:0]       rdata_q, cnt_q, cnt_d, term_cnt_a_q, term_cnt_b_q;
    logic             ack_q, lock_q, cal_q, recal_q, sync2_q, sync3_q;
    logic [1:0]       band1_q;
    slp_pll_t         st_q, st_d;
    logic [1:0]       band2_q, band3_q, band_q;

    wire              access   = bus.req && !ack_q;
    wire              wr       = access && bus.we;
    wire              in_tune  = bus.addr >= slp_pkg::OFS_TUNE_FIRST && bus.addr <= slp_pkg::OFS_TUNE_LAST;
    wire logic [4:0]  tune_idx = 5'(bus.addr - slp_pkg::OFS_TUNE_FIRST);
    wire              pll_en   = ctrl_q[slp_pkg::BIT_PLL_EN] && !if_power_q[slp_pkg::BIT_IF_PD];
    // recalibration fires on a 0-to-1 edge of the control bit
    wire              recal_rise = ctrl_q[slp_pkg::BIT_PLL_RECAL] && !recal_q;
    wire logic [7:0]  status = {2'h0, band_q[1], band_q[0], cal_q, 2'h0, lock_q};

    ////////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            if_power_q <= slp_pkg::RST_IF_POWER;
            pd_q       <= slp_pkg::RST_ZERO;
            eq_q       <= slp_pkg::RST_ZERO;
            ctrl_q     <= slp_pkg::RST_ZERO;
            div_q      <= slp_pkg::RST_ZERO;
            cdr_q      <= slp_pkg::RST_ZERO;
        end else if (wr) begin
            if (bus.addr == slp_pkg::OFS_IF_POWER)  if_power_q <= bus.wdata;
            if (bus.addr == slp_pkg::OFS_LANE_PD)   pd_q <= bus.wdata;
            if (bus.addr == slp_pkg::OFS_EQ_MODE)   eq_q <= bus.wdata;
            if (bus.addr == slp_pkg::OFS_PLL_CTRL)  ctrl_q <= bus.wdata;
            if (bus.addr == slp_pkg::OFS_PLL_DIV)   div_q <= bus.wdata;
            if (bus.addr == slp_pkg::OFS_CDR_RESET) cdr_q <= bus.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr && in_tune) begin
            tune_q[tune_idx] <= bus.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // termination autotune, one countdown per lane group
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            term_cnt_a_q <= slp_pkg::RST_ZERO;
            term_cnt_b_q <= slp_pkg::RST_ZERO;
            term_a_q     <= slp_pkg::RST_ZERO;
            term_b_q     <= slp_pkg::RST_ZERO;
        end else begin
            if (wr && bus.addr == slp_pkg::OFS_TERM_A) begin
                term_a_q     <= bus.wdata;
                term_cnt_a_q <= (bus.wdata == slp_pkg::TERM_START) ? slp_pkg::TERM_CYCLES : term_cnt_a_q;
            end else if (term_cnt_a_q != 8'h00) begin
                term_cnt_a_q <= term_cnt_a_q - 8'h01;
            end
            if (wr && bus.addr == slp_pkg::OFS_TERM_B) begin
                term_b_q     <= bus.wdata;
                term_cnt_b_q <= (bus.wdata == slp_pkg::TERM_START) ? slp_pkg::TERM_CYCLES : term_cnt_b_q;
            end else if (term_cnt_b_q != 8'h00) begin
                term_cnt_b_q <= term_cnt_b_q - 8'h01;
            end
        end
    end

    // lanes 0,1,6,7 belong to group a, lanes 2..5 to group b
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        localparam bit GRP_A = (i < 2) || (i > 5);
        assign term_tuning_o[i] = GRP_A ? (term_cnt_a_q != 8'h00) : (term_cnt_b_q != 8'h00);
        assign lane_active_o[i] = !pd_q[i] && !if_power_q[slp_pkg::BIT_IF_PD];
    end

    ////////////////////////////////////////////////////////////////////////
    // band-limit inputs come from the analog domain: three flops, second and third agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            band1_q <= 2'h0;
            band2_q <= 2'h0;
            band3_q <= 2'h0;
            band_q  <= 2'h0;
        end else begin
            band1_q <= {band_lo_i, band_hi_i};
            band2_q <= band1_q;
            band3_q <= band2_q;
            if (band2_q == band3_q) band_q <= band3_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pll state: off -> calibrate -> wait lock -> run
    always_comb begin
        st_d  = st_q;
        cnt_d = (cnt_q != 8'h00) ? cnt_q - 8'h01 : cnt_q;
        case (st_q)
            SLP_OFF: begin
                // enable starts calibration with the divider already set
                if (pll_en) begin
                    st_d  = SLP_CAL;
                    cnt_d = slp_pkg::CAL_CYCLES;
                end
            end
            SLP_CAL: begin
                if (cnt_q == 8'h00) begin
                    st_d  = SLP_LOCK;
                    cnt_d = slp_pkg::LOCK_CYCLES;
                end
            end
            SLP_LOCK: begin
                if (cnt_q == 8'h00) st_d = SLP_RUN;
            end
            SLP_RUN: ;
            default: st_d = SLP_OFF;
        endcase
        if (!pll_en) begin
            st_d = SLP_OFF;
        end else if (recal_rise) begin
            st_d  = SLP_CAL;
            cnt_d = slp_pkg::CAL_CYCLES;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q    <= SLP_OFF;
            cnt_q   <= 8'h00;
            recal_q <= 1'b0;
            lock_q  <= 1'b0;
            cal_q   <= 1'b0;
        end else begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            recal_q <= ctrl_q[slp_pkg::BIT_PLL_RECAL];
            lock_q  <= (st_d == SLP_RUN);
            cal_q   <= (st_d == SLP_LOCK) || (st_d == SLP_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register reads; one wait-free cycle, status read has no side effect
    wire logic [7:0] rd_mux =
        (bus.addr == slp_pkg::OFS_IF_POWER)  ? if_power_q :
        (bus.addr == slp_pkg::OFS_LANE_PD)   ? pd_q :
        (bus.addr == slp_pkg::OFS_EQ_MODE)   ? eq_q :
        (bus.addr == slp_pkg::OFS_PLL_CTRL)  ? ctrl_q :
        (bus.addr == slp_pkg::OFS_PLL_STAT)  ? status :
        (bus.addr == slp_pkg::OFS_PLL_DIV)   ? div_q :
        (bus.addr == slp_pkg::OFS_CDR_RESET) ? cdr_q :
        (bus.addr == slp_pkg::OFS_TERM_A)    ? term_a_q :
        (bus.addr == slp_pkg::OFS_TERM_B)    ? term_b_q :
        in_tune                              ? tune_q[tune_idx] : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q   <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            ack_q <= access;
            if (access) rdata_q <= rd_mux;
        end
    end
    assign bus.ack   = ack_q;
    assign bus.rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // interface powered when bit 0 is clear
    assign if_powered_o = !if_power_q[slp_pkg::BIT_IF_PD];
    assign eq_mode_o    = eq_q[slp_pkg::EQ_MSB:slp_pkg::EQ_LSB];
    assign cdr_reset_o  = cdr_q[slp_pkg::BIT_CDR_RESET];
    assign ref_divide_o = (div_q[1:0] == slp_pkg::DIV_OVERSAMP) ? 3'h1 :
                          (div_q[1:0] == slp_pkg::DIV_FULL)     ? 3'h2 : 3'h4;
    // ten bits per byte, four bytes per processing cycle
    assign bytes_per_pclk_o  = 8'(slp_pkg::BYTES_PER_PCLK);
    // frames per processing cycle; F above four gives zero
    assign frames_per_pclk_o = 8'(slp_pkg::BYTES_PER_PCLK / F_OCTET);
    // reference is lane rate over forty
    assign ref_ratio_o       = 8'(slp_pkg::REF_RATIO);
    assign vco_postdiv_o     = 8'(slp_pkg::VCO_POSTDIV);
endmodule // slp_phy_pll

// [logic/slp_ctrl.sv]
// module: wishbone-driven controller issuing register accesses to the front end
`timescale 1ns/10ps
module slp_ctrl (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // front end port
    slp_if.ctrl              bus
);
    logic [11:0] addr_q;
    logic [7:0]  wdata_q, rdata_q;
    logic        we_q, req_q, ack_q;

    wire wb_acc  = wb_cyc_i && wb_stb_i && !ack_q;
    // writes land on the edge that sees ack, so nothing acts before the master has its answer
    wire wb_wr   = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0];
    // a data register write launches a write access after a command with bit 12 set, a command write with bit 12 clear launches a read; software waits on busy
    wire go      = wb_wr && !req_q && (wb_adr_i == slp_pkg::WB_WDATA || wb_adr_i == slp_pkg::WB_CMD_ADDR);
    wire [31:0] rd_mux =
        (wb_adr_i == slp_pkg::WB_CMD_ADDR) ? {19'h0, we_q, addr_q} :
        (wb_adr_i == slp_pkg::WB_WDATA)    ? {24'h0, wdata_q} :
        (wb_adr_i == slp_pkg::WB_RDATA)    ? {24'h0, rdata_q} :
        (wb_adr_i == slp_pkg::WB_STATUS)   ? {31'h0, req_q} : 32'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_q  <= 12'h000;
            wdata_q <= 8'h00;
            we_q    <= 1'b0;
            req_q   <= 1'b0;
            rdata_q <= 8'h00;
            ack_q   <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ack_q <= wb_acc;
            if (wb_acc) wb_dat_o <= rd_mux;
            // sequencing is left to software, one access at a time
            if (go && wb_adr_i == slp_pkg::WB_CMD_ADDR) begin
                addr_q <= wb_dat_i[11:0];
                we_q   <= wb_dat_i[12];
                req_q  <= !wb_dat_i[12];
            end else if (go) begin
                wdata_q <= wb_dat_i[7:0];
                req_q   <= we_q;
            end else if (req_q && bus.ack) begin
                req_q <= 1'b0;
                if (!we_q) rdata_q <= bus.rdata;
            end
        end
    end
    assign wb_ack_o  = ack_q;
    assign bus.req   = req_q;
    assign bus.we    = we_q;
    assign bus.addr  = addr_q;
    assign bus.wdata = wdata_q;
endmodule // slp_ctrl

// [verification/slp_port_assertions.sv]
// checker: timing and cause assertions on the front end register port
`timescale 1ns/10ps
module slp_port_checker (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // register port
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [11:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic [7:0]  rdata,
    input  wire logic        ack,
    // front end outputs
    input  wire logic        if_powered_o,
    input  wire logic [7:0]  lane_active_o,
    input  wire logic [7:0]  term_tuning_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    property p_ack_lat; req && !ack |=> ack; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("port ack not one cycle after request");
    property p_ack_pulse; ack |=> !ack && !req; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("port ack or request held too long");
    property p_ack_cause; ack |-> $past(req) && req; endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("port ack without request");
    // a changing request would pair the answer with the wrong access
    property p_req_hold; req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata); endproperty
    a_req_hold: assert property (p_req_hold) else $error("port request changed before ack");
    property p_rdata_hold; $changed(rdata) |-> ack; endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved outside ack");
    property p_lanes_off; !if_powered_o |-> lane_active_o == 8'h00; endproperty
    a_lanes_off: assert property (p_lanes_off) else $error("lane active while interface down");
    property p_term_len; $rose(term_tuning_o[0]) |-> term_tuning_o[0] [*8] ##1 !term_tuning_o[0]; endproperty
    a_term_len: assert property (p_term_len) else $error("termination tune length wrong");
    property p_term_a; $rose(term_tuning_o[0]) |->
        $past(req && we && addr == slp_pkg::OFS_TERM_A && wdata == slp_pkg::TERM_START, 1) ||
        $past(req && we && addr == slp_pkg::OFS_TERM_A && wdata == slp_pkg::TERM_START, 2);
    endproperty
    a_term_a: assert property (p_term_a) else $error("group a tune without start write");
    property p_term_b; $rose(term_tuning_o[2]) |->
        $past(req && we && addr == slp_pkg::OFS_TERM_B && wdata == slp_pkg::TERM_START, 1) ||
        $past(req && we && addr == slp_pkg::OFS_TERM_B && wdata == slp_pkg::TERM_START, 2);
    endproperty
    a_term_b: assert property (p_term_b) else $error("group b tune without start write");
    ////////////////////////////////////////////////////////////////////////
    c_wr: cover property (ack && we);
    c_rd: cover property (ack && !we);
    c_tune_b: cover property ($rose(term_tuning_o[2]));
endmodule // slp_port_checker

// [verification/serial_lane_phy_pll_setup_tb.sv]
// testbench: wishbone controller and front end joined over the register port
`timescale 1ns/10ps
module serial_lane_phy_pll_setup_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [3:0]  wb_adr = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_rdat;
    logic        wb_ack;
    logic        band_hi = 1'b0;
    logic        band_lo = 1'b0;
    logic        if_powered;
    logic        cdr_rst;
    logic [7:0]  lane_active, term_tuning, bpp, fpp, ratio, postdiv;
    logic [1:0]  eq_mode;
    logic [2:0]  ref_div;
    logic [31:0] q;
    logic [7:0]  r;
    int          bad_count = 0;
    int          checks_done = 0;
    int          cycles = 0;
    initial forever #50 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////
    slp_if sif ();
    slp_ctrl slp_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .bus(sif));
    // two octets per frame gives two frames per processing cycle
    slp_phy_pll #(.F_OCTET(2)) slp_phy_pll_i (.clk_i(clk_i), .rst_i(rst_i), .bus(sif), .band_hi_i(band_hi),
        .band_lo_i(band_lo), .if_powered_o(if_powered), .lane_active_o(lane_active), .term_tuning_o(term_tuning),
        .eq_mode_o(eq_mode), .cdr_reset_o(cdr_rst), .ref_divide_o(ref_div), .bytes_per_pclk_o(bpp),
        .frames_per_pclk_o(fpp), .ref_ratio_o(ratio), .vco_postdiv_o(postdiv));
    slp_port_checker slp_port_checker_i (.clk_i(clk_i), .rst_i(rst_i), .req(sif.req), .we(sif.we),
        .addr(sif.addr), .wdata(sif.wdata), .rdata(sif.rdata), .ack(sif.ack), .if_powered_o(if_powered),
        .lane_active_o(lane_active), .term_tuning_o(term_tuning));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
            bad_count++;
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic idle();
        do wb(1'b0, slp_pkg::WB_STATUS, 32'h0); while (q[0] !== 1'b0);
    endtask
    task automatic fe_w(input logic [11:0] a, input logic [7:0] d);
        wb(1'b1, slp_pkg::WB_CMD_ADDR, {19'h0, 1'b1, a});
        wb(1'b1, slp_pkg::WB_WDATA, {24'h0, d});
    endtask
    task automatic fe_wi(input logic [11:0] a, input logic [7:0] d);
        fe_w(a, d);
        idle();
    endtask
    task automatic fe_r(input logic [11:0] a);
        wb(1'b1, slp_pkg::WB_CMD_ADDR, {20'h0, a});
        idle();
        wb(1'b0, slp_pkg::WB_RDATA, 32'h0);
        r = q[7:0];
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        fe_r(slp_pkg::OFS_IF_POWER);
        check("power reg", 8'h01, r);
        fe_r(slp_pkg::OFS_PLL_STAT);
        check("pll status", 8'h00, r);
        check("ref divide", 8'h04, {5'h0, ref_div});
        wb(1'b0, 4'h2, 32'h0);
        check("unmapped wb", 8'h00, q[7:0]);
        $display("test reset done");
    endtask
    task automatic t_power();
        fe_wi(slp_pkg::OFS_LANE_PD, 8'ha5);
        check("lanes while down", 8'h00, lane_active);
        fe_wi(slp_pkg::OFS_IF_POWER, 8'h00);
        check("powered", 8'h01, {7'h0, if_powered});
        check("lanes", 8'h5a, lane_active);
        fe_r(slp_pkg::OFS_LANE_PD);
        check("pd readback", 8'ha5, r);
        $display("test power done");
    endtask
    task automatic t_term(input logic [11:0] a, input logic [7:0] lanes);
        int n;
        n = 0;
        fe_w(a, slp_pkg::TERM_START);
        while (term_tuning === 8'h00 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        check("tuning lanes", lanes, term_tuning);
        idle();
        repeat (10) @(posedge clk_i);
        check("tuning over", 8'h00, term_tuning);
        fe_wi(a, 8'h02);
        check("no tune on other value", 8'h00, term_tuning);
        $display("test termination done");
    endtask
    task automatic t_modes();
        for (int c = 0; c < 4; c++) begin
            fe_wi(slp_pkg::OFS_EQ_MODE, {c[1:0], 6'h15});
            check("eq mode", {6'h0, c[1:0]}, {6'h0, eq_mode});
        end
        for (int c = 0; c < 3; c++) begin
            fe_wi(slp_pkg::OFS_PLL_DIV, {6'h0, c[1:0]});
            check("divide", 8'h04 >> c, {5'h0, ref_div});
        end
        check("bytes per pclk", 8'h04, bpp);
        check("frames per pclk", 8'h02, fpp);
        check("ref ratio", 8'h28, ratio);
        check("vco postdiv", 8'h02, postdiv);
        $display("test modes done");
    endtask
    task automatic t_recovery();
        fe_wi(slp_pkg::OFS_CDR_RESET, 8'h01);
        check("recovery reset held", 8'h01, {7'h0, cdr_rst});
        fe_wi(slp_pkg::OFS_CDR_RESET, 8'h00);
        check("recovery reset released", 8'h00, {7'h0, cdr_rst});
        fe_wi(slp_pkg::OFS_TUNE_FIRST, 8'h5c);
        fe_wi(slp_pkg::OFS_TUNE_LAST, 8'ha3);
        fe_r(slp_pkg::OFS_TUNE_FIRST);
        check("tune first", 8'h5c, r);
        fe_r(slp_pkg::OFS_TUNE_LAST);
        check("tune last", 8'ha3, r);
        $display("test recovery done");
    endtask
    task automatic t_pll();
        fe_wi(slp_pkg::OFS_PLL_DIV, {6'h0, slp_pkg::DIV_FULL});
        fe_wi(slp_pkg::OFS_PLL_CTRL, 8'h01);
        fe_r(slp_pkg::OFS_PLL_STAT);
        check("calibrating", 8'h00, r);
        repeat (80) @(posedge clk_i);
        fe_r(slp_pkg::OFS_PLL_STAT);
        check("locked", 8'h09, r);
        fe_r(slp_pkg::OFS_PLL_STAT);
        check("reread", 8'h09, r);
        band_hi <= 1'b1;
        repeat (6) @(posedge clk_i);
        fe_r(slp_pkg::OFS_PLL_STAT);
        check("band high", 8'h19, r);
        band_hi <= 1'b0;
        band_lo <= 1'b1;
        repeat (6) @(posedge clk_i);
        fe_r(slp_pkg::OFS_PLL_STAT);
        check("band low", 8'h29, r);
        band_lo <= 1'b0;
        repeat (6) @(posedge clk_i);
        fe_wi(slp_pkg::OFS_PLL_CTRL, 8'h01);
        fe_wi(slp_pkg::OFS_PLL_CTRL, 8'h05);
        fe_r(slp_pkg::OFS_PLL_STAT);
        check("recalibrating", 8'h00, r & 8'h09);
        repeat (80) @(posedge clk_i);
        fe_r(slp_pkg::OFS_PLL_STAT);
        check("relocked", 8'h09, r);
        $display("test pll done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_power();
        t_term(slp_pkg::OFS_TERM_A, 8'hc3);
        t_term(slp_pkg::OFS_TERM_B, 8'h3c);
        t_modes();
        t_recovery();
        t_pll();
        conclude();
    end
endmodule // serial_lane_phy_pll_setup_tb
